// File: adcc_regs.vh
// register map, field positions, reset values and timing counts of the
// converter control block; assumes a 32-bit apb with byte addresses.
`ifndef ADCC_REGS_VH
`define ADCC_REGS_VH

// register indices; byte address is four times the index
`define ADCC_IDX_CTRL       10'h0C0
`define ADCC_IDX_RES_LOW    10'h0C1
`define ADCC_IDX_RES_HIGH   10'h0C2
`define ADCC_IDX_PIN_SEL    10'h0C5
`define ADCC_IDX_IRQ_STAT   10'h0D0
`define ADCC_IDX_IRQ_MASK   10'h0D1

// converter_control fields
`define ADCC_CTRL_ENABLE    7
`define ADCC_CTRL_EXT_EN    5
`define ADCC_CTRL_DONE      4
`define ADCC_CTRL_BUSY      3
`define ADCC_CTRL_CH_HI     2
`define ADCC_CTRL_CH_LO     0

// conv_result_low fields
`define ADCC_RESL_CLK_HI    7
`define ADCC_RESL_CLK_LO    6

// interrupt status / mask bits
`define ADCC_IRQ_DONE       0
`define ADCC_IRQ_REFUSED    1

// reset values
`define ADCC_RST_CHANNEL    3'h0
`define ADCC_RST_CLK_SEL    2'h0
`define ADCC_RST_PIN_SEL    4'h0
`define ADCC_RST_MASK       2'h0

// converter clock select codes and divide ratios
`define ADCC_CLK_DIV4       2'h0
`define ADCC_CLK_DIV8       2'h1
`define ADCC_CLK_DIV16      2'h2
`define ADCC_DIV4_LAST      4'h3
`define ADCC_DIV8_LAST      4'h7
`define ADCC_DIV16_LAST     4'hF

`endif

// File: adcc_top.v
// converter control block: start/busy/done handshake with the analog
// macro, channel interlock, clock divider, result and pin-select registers.
// assumes the analog macro runs on core_clk_in and pulses its ready line;
// the trigger pin is asynchronous and is synchronised here.
//
// The APB register port was left to the implementer.
`include "adcc_regs.vh"

module adcc_top (
  input  wire        core_clk_in,        // system clock, 125 MHz
  input  wire        rst_in,             // async reset, active high
  input  wire        psel_in,            // apb select
  input  wire        penable_in,         // apb access phase
  input  wire        pwrite_in,          // apb direction, 1 = write
  input  wire [11:0] paddr_in,           // apb byte address
  input  wire [31:0] pwdata_in,          // apb write data
  output reg  [31:0] prdata_out,         // apb read data
  output reg         pready_out,         // apb ready
  output reg         pslverr_out,        // apb error, unmapped address
  input  wire        conv_trigger_pin_in,// external trigger pin, async
  input  wire        conv_ready_in,      // macro result ready, one-cycle pulse
  input  wire [9:0]  conv_result_in,     // macro result, valid with ready
  output reg         conv_start_out,     // one-cycle start pulse to macro
  output reg  [2:0]  conv_channel_out,   // selected analog channel code
  output reg         conv_clk_en_out,    // divided converter clock enable
  output reg         converter_enable_out,// macro power/enable level
  output reg  [3:0]  analog_pin_sel_out, // pins switched to analog input
  output reg         irq_out             // level interrupt request
);

  // control state
  reg        conv_done_flag_reg;         // result ready flag
  reg        conv_start_busy_reg;        // conversion in progress
  reg        ext_trigger_enable_reg;     // pin start allowed
  reg        converter_enable_reg;       // macro enable bit
  reg  [2:0] channel_reg;                // channel select field
  reg  [1:0] clk_sel_reg;                // converter clock select
  reg  [3:0] pin_sel_reg;                // analog pin switches
  reg  [9:0] result_reg;                 // latched conversion result
  reg  [1:0] irq_stat_reg;               // sticky event bits
  reg  [1:0] irq_mask_reg;               // event enables

  // divider
  reg  [3:0] div_cnt_reg;                // converter clock prescaler
  reg  [3:0] div_last;                   // terminal count for select

  // trigger pin synchroniser and edge detector
  reg        trig_meta_reg;              // first stage, read only by second
  reg        trig_sync_reg;              // second stage
  reg        trig_prev_reg;              // delayed copy for edge detect
  wire       trig_rise;                  // synchronised rising edge

  // bus decode
  wire       setup_ph;                   // apb setup cycle
  wire       access_done;                // access edge with ready
  wire       wr_access;                  // write takes effect now
  wire [9:0] reg_idx;                    // word index of address
  wire       addr_aligned;               // low address bits zero
  reg        addr_hit;                   // address maps to a register
  reg [31:0] rd_mux;                     // read data for current address

  // per-register write strobes
  wire       wr_ctrl;                    // converter_control write
  wire       wr_resl;                    // conv_result_low write
  wire       wr_pin;                     // analog_pin_select write
  wire       wr_stat;                    // interrupt status write
  wire       wr_mask;                    // interrupt mask write

  // start arbitration
  wire       done_after_wr;              // done flag value once write applied
  wire       sw_start_req;               // software asks for a start
  wire       hw_start_req;               // pin asks for a start
  wire       start_allowed;              // interlock open
  wire       start_go;                   // conversion launches this cycle
  wire       start_refused;              // request dropped by interlock

  // status bits and events
  reg        conv_done_flag_next;        // next done flag
  reg        conv_start_busy_next;       // next busy bit
  reg  [1:0] irq_stat_next;              // next sticky status
  wire [1:0] irq_event;                  // events raised this cycle

  assign setup_ph     = psel_in & ~penable_in;
  assign access_done  = psel_in & penable_in & pready_out;
  assign wr_access    = access_done & pwrite_in & ~pslverr_out;
  assign reg_idx      = paddr_in[11:2];
  assign addr_aligned = (paddr_in[1:0] == 2'h0);

  assign wr_ctrl = wr_access & (reg_idx == `ADCC_IDX_CTRL);
  assign wr_resl = wr_access & (reg_idx == `ADCC_IDX_RES_LOW);
  assign wr_pin  = wr_access & (reg_idx == `ADCC_IDX_PIN_SEL);
  assign wr_stat = wr_access & (reg_idx == `ADCC_IDX_IRQ_STAT);
  assign wr_mask = wr_access & (reg_idx == `ADCC_IDX_IRQ_MASK);

  // trigger pin crosses into the clock domain through two flops
  // the pin may move at any instant, so only the second stage is trusted;
  // this costs three clocks from pin edge to start, well below anything a
  // converter this slow could follow anyway
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      trig_meta_reg <= 1'b0;
      trig_sync_reg <= 1'b0;
      trig_prev_reg <= 1'b0;
    end else begin
      trig_meta_reg <= conv_trigger_pin_in;
      trig_sync_reg <= trig_meta_reg;
      trig_prev_reg <= trig_sync_reg;
    end
  end

  // edge taken from the second stage only, never the first
  assign trig_rise = trig_sync_reg & ~trig_prev_reg;

  // a write of zero to the done bit clears it; a one leaves it alone
  assign done_after_wr = (wr_ctrl & ~pwdata_in[`ADCC_CTRL_DONE]) ? 1'b0 : conv_done_flag_reg;

  assign sw_start_req = wr_ctrl & pwdata_in[`ADCC_CTRL_BUSY];

  // pin edge counts only when enabled
  assign hw_start_req = ext_trigger_enable_reg & trig_rise;

  // the ready cycle refuses a start too, so a result and a launch never
  // share an edge; software sees that as a refused-start event
  // the done term uses the value after this write, which lets one write
  // clear done and start at once
  // done flag blocks; busy blocks; same-write clear opens
  assign start_allowed = ~conv_start_busy_reg & ~done_after_wr & ~conv_ready_in;

  // pin event or software bit starts conversion
  assign start_go      = (sw_start_req | hw_start_req) & start_allowed;
  assign start_refused = (sw_start_req | hw_start_req) & ~start_allowed;

  // done and busy next values
  // ready outside a conversion is dropped: it neither sets done nor
  // touches the result, so a stray pulse from the macro can at worst refuse a start in its cycle
  always @* begin
    conv_done_flag_next  = done_after_wr;
    conv_start_busy_next = conv_start_busy_reg;
    // completion sets the flag; set beats a same-cycle clear
    if (conv_ready_in && conv_start_busy_reg) begin
      conv_done_flag_next  = 1'b1;
      conv_start_busy_next = 1'b0;
    end else if (start_go) begin
      conv_start_busy_next = 1'b1;
    end
    // a written zero never reaches the busy bit
  end

  // done flag only set here by hardware, cleared by write above
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      conv_done_flag_reg  <= 1'b0;
      conv_start_busy_reg <= 1'b0;
    end else begin
      conv_done_flag_reg  <= conv_done_flag_next;
      conv_start_busy_reg <= conv_start_busy_next;
    end
  end

  // result captured on the edge that sets done
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      result_reg <= 10'h000;
    end else if (conv_ready_in && conv_start_busy_reg) begin
      result_reg <= conv_result_in;
    end
  end

  // plain control bits of converter_control
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ext_trigger_enable_reg <= 1'b0;
      converter_enable_reg   <= 1'b0;
    end else if (wr_ctrl) begin
      ext_trigger_enable_reg <= pwdata_in[`ADCC_CTRL_EXT_EN];
      converter_enable_reg   <= pwdata_in[`ADCC_CTRL_ENABLE];
    end
  end

  // channel field, locked while a conversion is pending or unread
  // the lock reads the flags as they stand, not after this write, so a
  // write that clears done cannot move the channel in the same access
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      channel_reg <= `ADCC_RST_CHANNEL;
    end else if (wr_ctrl) begin
      // only when done and busy both clear
      if (!conv_done_flag_reg && !conv_start_busy_reg) begin
        channel_reg <= pwdata_in[`ADCC_CTRL_CH_HI:`ADCC_CTRL_CH_LO];
      end
    end
  end

  // clock select lives in the low result register; result bits ignore writes
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      clk_sel_reg <= `ADCC_RST_CLK_SEL;
    end else if (wr_resl) begin
      clk_sel_reg <= pwdata_in[`ADCC_RESL_CLK_HI:`ADCC_RESL_CLK_LO];
    end
  end

  // pin select; upper bits are not stored and read back as zero
  // software must write the upper bits as zero; not storing them means a
  // careless write has no side effect on the port pins
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pin_sel_reg <= `ADCC_RST_PIN_SEL;
    end else if (wr_pin) begin
      pin_sel_reg <= pwdata_in[3:0];
    end
  end

  // terminal count per select; reserved code kept at the slowest rate
  always @* begin
    case (clk_sel_reg)
      `ADCC_CLK_DIV4:  div_last = `ADCC_DIV4_LAST;
      `ADCC_CLK_DIV8:  div_last = `ADCC_DIV8_LAST;
      `ADCC_CLK_DIV16: div_last = `ADCC_DIV16_LAST;
      default:         div_last = `ADCC_DIV16_LAST;
    endcase
  end

  // prescaler; restarts cleanly if the select shrinks under the count
  // free-running from reset and not aligned to starts, so the first
  // macro clock after a start may come up to one period late; the >=
  // compare keeps a shrinking select from running the count past its end
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      div_cnt_reg     <= 4'h0;
      conv_clk_en_out <= 1'b0;
    end else if (div_cnt_reg >= div_last) begin
      div_cnt_reg     <= 4'h0;
      conv_clk_en_out <= 1'b1;
    end else begin
      div_cnt_reg     <= div_cnt_reg + 4'h1;
      conv_clk_en_out <= 1'b0;
    end
  end

  // interrupt events: completion and refused start
  assign irq_event[`ADCC_IRQ_DONE]    = conv_ready_in & conv_start_busy_reg;
  assign irq_event[`ADCC_IRQ_REFUSED] = start_refused;

  // sticky status, write one to clear, new event wins over the clear
  // mask bits only gate the request; status records every event anyway,
  // so software can poll with the interrupt masked off
  always @* begin
    irq_stat_next = irq_stat_reg;
    if (wr_stat) begin
      irq_stat_next = irq_stat_reg & ~pwdata_in[1:0];
    end
    irq_stat_next = irq_stat_next | irq_event;
  end

  // status and mask registers
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_stat_reg <= 2'h0;
      irq_mask_reg <= `ADCC_RST_MASK;
    end else begin
      irq_stat_reg <= irq_stat_next;
      if (wr_mask) begin
        irq_mask_reg <= pwdata_in[1:0];
      end
    end
  end

  // read mux; all fields sit in the low byte, upper bits zero
  // reserved bits read as zero; the result bits are read only and are
  // never touched by a write to the low result register
  always @* begin
    rd_mux   = 32'h00000000;
    addr_hit = addr_aligned;
    case (reg_idx)
      `ADCC_IDX_CTRL: begin
        // done and busy read side by side as the status pair
        rd_mux[`ADCC_CTRL_ENABLE] = converter_enable_reg;
        rd_mux[`ADCC_CTRL_EXT_EN] = ext_trigger_enable_reg;
        rd_mux[`ADCC_CTRL_DONE]   = conv_done_flag_reg;
        rd_mux[`ADCC_CTRL_BUSY]   = conv_start_busy_reg;
        rd_mux[`ADCC_CTRL_CH_HI:`ADCC_CTRL_CH_LO] = channel_reg;
      end
      `ADCC_IDX_RES_LOW: begin
        // two lsbs beside the clock select
        rd_mux[`ADCC_RESL_CLK_HI:`ADCC_RESL_CLK_LO] = clk_sel_reg;
        rd_mux[1:0] = result_reg[1:0];
      end
      `ADCC_IDX_RES_HIGH: begin
        // eight msbs, bit 7 is result bit 9
        rd_mux[7:0] = result_reg[9:2];
      end
      `ADCC_IDX_PIN_SEL: begin
        rd_mux[3:0] = pin_sel_reg;
      end
      `ADCC_IDX_IRQ_STAT: begin
        rd_mux[1:0] = irq_stat_reg;
      end
      `ADCC_IDX_IRQ_MASK: begin
        rd_mux[1:0] = irq_mask_reg;
      end
      default: begin
        addr_hit = 1'b0;
      end
    endcase
  end

  // trade-off: one fixed access cycle keeps the slave small, at the cost
  // of reads showing state sampled at the setup edge
  // unmapped or misaligned addresses answer with an error and zero data
  // apb slave: ready one cycle after setup, data captured at setup;
  // a read thus reflects state one cycle before the access edge
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h00000000;
    end else if (setup_ph) begin
      pready_out  <= 1'b1;
      pslverr_out <= ~addr_hit;
      prdata_out  <= (pwrite_in | ~addr_hit) ? 32'h00000000 : rd_mux;
    end else begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
    end
  end

  // outputs to the analog side, all from flops
  // registering every output delays start and channel by one clock; the
  // channel field is itself a flop, so a write that sets channel and start
  // together puts the new channel code out one clock after the start pulse
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      conv_start_out       <= 1'b0;
      conv_channel_out     <= `ADCC_RST_CHANNEL;
      converter_enable_out <= 1'b0;
      analog_pin_sel_out   <= `ADCC_RST_PIN_SEL;
      irq_out              <= 1'b0;
    end else begin
      conv_start_out       <= start_go;
      // channel code goes straight to the input mux
      conv_channel_out     <= channel_reg;
      converter_enable_out <= converter_enable_reg;
      analog_pin_sel_out   <= pin_sel_reg;
      irq_out              <= |(irq_stat_next & irq_mask_reg);
    end
  end

endmodule // adcc_top

// File: adcc_top_asserts.sv
// concurrent checks of the converter control block at its top ports
// assumes the macro answers only after a start pulse; bound below
`include "adcc_regs.vh"
module adcc_top_asserts (
  input wire        core_clk_in,         // clock
  input wire        rst_in,              // async reset
  input wire        psel_in,             // apb select
  input wire        penable_in,          // apb access
  input wire        pwrite_in,           // apb direction
  input wire [11:0] paddr_in,            // apb address
  input wire [31:0] pwdata_in,           // apb write data
  input wire        pready_out,          // apb ready
  input wire        conv_trigger_pin_in, // trigger pin
  input wire        conv_ready_in,       // macro ready
  input wire        conv_start_out,      // start pulse
  input wire [2:0]  conv_channel_out,    // channel code
  input wire        conv_clk_en_out,     // divided clock enable
  input wire [3:0]  analog_pin_sel_out,  // analog pins
  input wire        irq_out              // interrupt
);
  timeunit 1ns;
  timeprecision 1ps;
  // write access edges per register
  wire wr    = psel_in && penable_in && pready_out && pwrite_in;
  wire w_ctl = wr && paddr_in == {`ADCC_IDX_CTRL, 2'h0};
  wire w_ps  = wr && paddr_in == {`ADCC_IDX_PIN_SEL, 2'h0};
  wire w_msk = wr && paddr_in == {`ADCC_IDX_IRQ_MASK, 2'h0};
  reg  busy_reg, done_reg, ext_reg, mask_reg; // shadow state

  // shadow state; busy rises one edge after the design's and falls on the same edge, safe for these checks
  always @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      ext_reg  <= 1'b0;
      mask_reg <= 1'b0;
    end else begin
      if (conv_start_out) busy_reg <= 1'b1;
      else if (conv_ready_in) busy_reg <= 1'b0;
      // set beats clear
      if (busy_reg && conv_ready_in) done_reg <= 1'b1;
      else if (w_ctl && !pwdata_in[4]) done_reg <= 1'b0;
      if (w_ctl) ext_reg <= pwdata_in[5];
      if (w_msk) mask_reg <= pwdata_in[0];
    end
  end

  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  chk_start_blocked: assert property ((busy_reg || done_reg) |-> !conv_start_out)
    else $error("start while busy or done");
  chk_sw_start: assert property (w_ctl && pwdata_in[3] && !busy_reg && !conv_start_out
    && !(done_reg && pwdata_in[4]) && !conv_ready_in |=> conv_start_out)
    else $error("software start dropped");
  chk_irq_raise: assert property (busy_reg && conv_ready_in && mask_reg |-> ##2 irq_out)
    else $error("no interrupt after result");
  chk_chan_lock: assert property ((busy_reg || done_reg) |=> $stable(conv_channel_out))
    else $error("channel changed while locked");
  chk_chan_route: assert property (w_ctl && !busy_reg && !done_reg && !conv_start_out
    |-> ##2 conv_channel_out == $past(pwdata_in[2:0], 2))
    else $error("channel not taken");
  chk_clk_min: assert property (conv_clk_en_out |=> !conv_clk_en_out [*3])
    else $error("divider gap below four");
  chk_clk_max: assert property (conv_clk_en_out |=> ##[0:15] conv_clk_en_out)
    else $error("divider gap above sixteen");
  chk_trig_start: assert property ($rose(conv_trigger_pin_in) && ext_reg
    && !busy_reg && !done_reg |-> ##[2:4] conv_start_out)
    else $error("trigger start missing");
  chk_pin_sel: assert property (w_ps |-> ##2 analog_pin_sel_out == $past(pwdata_in[3:0], 2))
    else $error("pin select not taken");
endmodule // adcc_top_asserts

bind adcc_top adcc_top_asserts u_chk (.core_clk_in(core_clk_in), .rst_in(rst_in),
  .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .pwdata_in(pwdata_in), .pready_out(pready_out), .conv_trigger_pin_in(conv_trigger_pin_in),
  .conv_ready_in(conv_ready_in), .conv_start_out(conv_start_out),
  .conv_channel_out(conv_channel_out), .conv_clk_en_out(conv_clk_en_out),
  .analog_pin_sel_out(analog_pin_sel_out), .irq_out(irq_out));

// File: adcc_macro_model.sv
// behavioural analog converter macro: answers a start after a delay
// assumes delay_in of two or more; result lines churn outside the pulse
module adcc_macro_model (
  input  wire logic       clk_in,     // system clock
  input  wire logic       rst_in,     // async reset
  input  wire logic       start_in,   // start pulse
  input  wire logic [7:0] delay_in,   // cycles to answer
  input  wire logic [9:0] value_in,   // result to deliver
  output logic            ready_out,  // one-cycle ready
  output logic [9:0]      result_out  // result, valid with ready
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt; // cycles left
  initial begin
    ready_out = 1'b0;
    result_out = 10'h000;
  end
  // inverted lines outside ready, so stale data never looks valid
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt <= 0;
      ready_out <= 1'b0;
      result_out <= 10'h000;
    end else begin
      ready_out <= 1'b0;
      result_out <= ~result_out;
      if (start_in) cnt <= delay_in;
      else if (cnt == 1) begin
        ready_out <= 1'b1;
        result_out <= value_in;
        cnt <= 0;
      end else if (cnt > 1) cnt <= cnt - 1;
    end
  end
endmodule // adcc_macro_model

// File: tb_adcc_top.sv
// self-checking bench for the converter control block
// assumes the macro model; apb driven by nba after rising edges
`include "adcc_regs.vh"
module tb_adcc_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam [11:0] A_CTL = {`ADCC_IDX_CTRL, 2'h0};
  localparam [11:0] A_RL = {`ADCC_IDX_RES_LOW, 2'h0};
  localparam [11:0] A_RH = {`ADCC_IDX_RES_HIGH, 2'h0};
  localparam [11:0] A_PS = {`ADCC_IDX_PIN_SEL, 2'h0};
  localparam [11:0] A_ST = {`ADCC_IDX_IRQ_STAT, 2'h0};
  localparam [11:0] A_MK = {`ADCC_IDX_IRQ_MASK, 2'h0};
  logic        clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, trig = 0, e;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, r, seed = 32'h0001_11FA;
  logic [9:0]  val = 10'h000;   // expected result
  logic [7:0]  dly = 8'h02;     // macro delay
  logic [1:0]  m_clk = 2'h3;    // clock select after divider test
  logic [9:0]  exp_q[$];        // results owed, in launch order
  wire  [31:0] prdata;
  wire  [9:0]  mres;
  wire  [2:0]  chan;
  wire  [3:0]  pins;
  wire         pready, perr, start, ready, clken, cen, irq;
  int          n_fail = 0, tests_run = 0, nst = 0, m_st = 0, g, c;

  adcc_top dut (.core_clk_in(clk), .rst_in(rst), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(perr), .conv_trigger_pin_in(trig),
    .conv_ready_in(ready), .conv_result_in(mres), .conv_start_out(start),
    .conv_channel_out(chan), .conv_clk_en_out(clken), .converter_enable_out(cen),
    .analog_pin_sel_out(pins), .irq_out(irq));
  adcc_macro_model mdl (.clk_in(clk), .rst_in(rst), .start_in(start), .delay_in(dly),
    .value_in(val), .ready_out(ready), .result_out(mres));

  initial forever #4 clk = ~clk;
  // launches seen at the macro
  always @(posedge clk) if (start === 1'b1) nst <= nst + 1;
  initial begin #400000; fail("run hang"); end_of_test; end

  function automatic [31:0] xs(input [31:0] s);
    s ^= s << 13; s ^= s >> 17; s ^= s << 5;
    return s;
  endfunction
  task fail(input string m); $display("unexpected %0t %s", $time, m); n_fail++; endtask
  task cmp(input [31:0] got, input [31:0] x, input string m);
    tests_run++;
    if (got !== x) fail(m);
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // one apb transfer; ready and data taken at the rising edge that completes
  // it, read before that edge's updates land, then the request is released
  task apb(input [11:0] a, input w, input [31:0] d);
    int k;
    @(posedge clk); psel <= 1; pen <= 0; paddr <= a; pwr <= w; pwdata <= d;
    @(posedge clk); pen <= 1;
    for (k = 0; k < 20; k++) begin @(posedge clk); if (pready === 1'b1) break; end
    if (k == 20) begin fail("apb hang"); end_of_test; end
    r = prdata; e = perr;
    psel <= 0; pen <= 0;
  endtask
  task rd(input [11:0] a, input [31:0] x, input string m); apb(a, 0, 0); cmp(r, x, m); endtask
  task waitirq;
    int k;
    for (k = 0; k < 300 && irq !== 1'b1; k++) @(negedge clk);
    if (k == 300) begin fail("no interrupt"); end_of_test; end
  endtask
  task nxt; @(negedge clk); g = 1; while (clken !== 1'b1 && g < 40) begin @(negedge clk); g++; end endtask
  task res_chk;
    logic [9:0] x;
    cmp(exp_q.size(), 1, "results owed");
    x = exp_q.size() > 0 ? exp_q.pop_front() : 10'h000;
    rd(A_RH, {24'h0, x[9:2]}, "high result");
    rd(A_RL, {24'h0, m_clk, 4'h0, x[1:0]}, "low result");
    cmp(nst, m_st, "launch count");
  endtask
  task launch(input [31:0] w, input [7:0] d);
    seed = xs(seed); val = seed[9:0]; dly = d; m_st++; exp_q.push_back(val);
    apb(A_CTL, 1, w);
  endtask
  task pulse; @(posedge clk); trig <= 1; repeat (3) @(posedge clk); trig <= 0; endtask

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd(A_CTL, 0, "reset ctrl"); rd(A_RL, 0, "reset low"); rd(A_RH, 0, "reset high");
    rd(A_PS, 0, "reset pins"); rd(A_ST, 0, "reset stat"); rd(A_MK, 0, "reset mask");
    apb(12'h3FC, 0, 0); cmp(e, 1, "unmapped error");
    seed = xs(seed); apb(A_PS, 1, {28'h0, seed[3:0]});
    rd(A_PS, {28'h0, seed[3:0]}, "pin select");
    cmp(pins, seed[3:0], "pin output");
    $display("test registers done");
    // every divider code; last one slowest, left in place for the converter
    for (c = 0; c < 4; c++) begin
      apb(A_RL, 1, {24'h0, 2'(c), 6'h3F}); rd(A_RL, {24'h0, 2'(c), 6'h00}, "clock sel");
      nxt; nxt; cmp(g, c == 0 ? 4 : c == 1 ? 8 : 16, "divider gap");
    end
    $display("test divider done");
    apb(A_MK, 1, 3);
    for (c = 0; c < 4; c++) begin
      launch(32'h88 | c, {2'h0, seed[5:0]} + 8'h02); waitirq;
      rd(A_CTL, 32'h90 | c, "done status"); cmp(chan, c, "channel"); res_chk;
      apb(A_CTL, 1, 32'h98 | ((c + 1) & 3)); rd(A_CTL, 32'h90 | c, "refused");
      rd(A_ST, 3, "status bits"); apb(A_ST, 1, 3); rd(A_ST, 0, "status clear");
      cmp(irq, 0, "irq low"); apb(A_CTL, 1, 32'h80 | c); rd(A_CTL, 32'h80 | c, "cleared");
    end
    $display("test channels done");
    apb(A_MK, 1, 1);
    launch(32'h88, 8'h3C); apb(A_CTL, 1, 32'h81); apb(A_CTL, 1, 32'h88);
    rd(A_CTL, 32'h88, "busy held"); waitirq; rd(A_CTL, 32'h90, "busy done"); res_chk;
    apb(A_ST, 1, 3); launch(32'h88, 8'h05); waitirq; res_chk;
    rd(A_ST, 1, "no refusal");
    $display("test busy done");
    apb(A_CTL, 1, 32'h80); apb(A_ST, 1, 3); pulse; repeat (10) @(posedge clk);
    cmp(nst, m_st, "trigger ignored");
    apb(A_CTL, 1, 32'hA0); seed = xs(seed); val = seed[9:0]; m_st++;
    exp_q.push_back(val); pulse; waitirq;
    rd(A_CTL, 32'hB0, "trigger done"); res_chk; cmp(cen, 1, "enable level");
    $display("test trigger done");
    end_of_test;
  end
endmodule // tb_adcc_top
